// [rtl/kef_pkg.sv]
// Shared field layout and reset values for the key event flag bank
package kef_pkg;
	localparam int unsigned NUM_KEYS = 3;
	localparam int unsigned FLAG_W = 5;
	localparam int unsigned REG_W = 8;
	localparam int unsigned CNT_W = 24;
	localparam int unsigned BIT_K1_PRESS = 0;
	localparam int unsigned BIT_K1_RELEASE = 1;
	localparam int unsigned BIT_K2_PRESS = 2;
	localparam int unsigned BIT_K2_RELEASE = 3;
	localparam int unsigned BIT_K3_PRESS = 4;
	localparam logic [FLAG_W-1:0] FLAGS_RST = 5'h0_0;
	localparam logic KEY_DETECT_ENABLE_RST = 1'b1;
	localparam logic [1:0] SYNC_RST = 2'h0;
endpackage : kef_pkg

// [rtl/kef_debounce.sv]
// Per-key debouncer qualifying press and release events
`timescale 1ns/1ps
module kef_debounce #(
	parameter int unsigned CNT_W = kef_pkg::CNT_W
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic enable_i,
	input wire logic level_i,
	input wire logic [CNT_W-1:0] press_cyc_i,
	input wire logic [CNT_W-1:0] release_cyc_i,
	output logic press_o,
	output logic release_o
);
	logic state_q;
	logic [CNT_W-1:0] cnt_q;
	logic differ;
	logic [CNT_W-1:0] limit;

	assign differ = level_i != state_q;
	assign limit = state_q ? release_cyc_i : press_cyc_i;
	// One more differing cycle than the limit makes the key condition longer than it
	assign press_o = enable_i && differ && !state_q && (cnt_q == limit);
	assign release_o = enable_i && differ && state_q && (cnt_q == limit);

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= 1'b0;
			cnt_q <= '0;
		end
		else if (!enable_i)
		begin
			// Disabled keys forget their state so a later enable starts from released
			state_q <= 1'b0;
			cnt_q <= '0;
		end
		else if (!differ)
		begin
			cnt_q <= '0;
		end
		else if (cnt_q == limit)
		begin
			state_q <= level_i;
			cnt_q <= '0;
		end
		else
		begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	AST_DB_PRESS_HELD: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		press_o |-> level_i && (cnt_q == press_cyc_i))
		else $error("press qualified before debounce time");
	AST_DB_RELEASE_HELD: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		release_o |-> !level_i && (cnt_q == release_cyc_i))
		else $error("release qualified before debounce time");
endmodule : kef_debounce

// [rtl/kef_flags.sv]
// Key 1 and 2 press and release, key 3 press event flag bits with read-to-clear
//
// Function
// - Press flags set after press debounce time.
// - Release flags set after release debounce time.
// - Host register read clears all flags except those set in the read cycle.
// - Detection enable at zero clears all flags.
// - Removal clears enable, and so the flags.
// - Press flag set clears same key's release.
// - Key 1 flags report synchronised, debounced events.
`timescale 1ns/1ps
module kef_flags #(
	parameter int unsigned CNT_W = kef_pkg::CNT_W
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [kef_pkg::NUM_KEYS-1:0] key_pressed_i,
	input wire logic [CNT_W-1:0] press_cyc_i,
	input wire logic [CNT_W-1:0] release_cyc_i,
	input wire logic key_detect_enable_wr_i,
	input wire logic key_detect_enable_wdata_i,
	input wire logic removal_i,
	input wire logic read_done_i,
	output logic key_detect_enable_o,
	output logic [kef_pkg::REG_W-1:0] rd_data_o
);
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [kef_pkg::NUM_KEYS-1:0] key_meta_q;
	logic [kef_pkg::NUM_KEYS-1:0] key_sync_q;
	logic [kef_pkg::NUM_KEYS-1:0] press_evt;
	logic [kef_pkg::NUM_KEYS-1:0] release_evt;
	logic enable_q;
	logic [kef_pkg::FLAG_W-1:0] flags_q;
	logic [kef_pkg::FLAG_W-1:0] flags_d;

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rst_sync_q <= kef_pkg::SYNC_RST;
		end
		else
		begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Key levels come from the analog detector, so they are synchronised first
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			key_meta_q <= '0;
			key_sync_q <= '0;
		end
		else
		begin
			key_meta_q <= key_pressed_i;
			key_sync_q <= key_meta_q;
		end
	end

	// Each key has its own debouncer; they share the timer settings and the detection enable
	for (genvar k = 0; k < kef_pkg::NUM_KEYS; k++)
	begin : g_key
		kef_debounce #(
			.CNT_W(CNT_W)
		) u_debounce (
			.ref_clk_i(ref_clk_i),
			.rst_n_i(rst_n),
			.enable_i(enable_q),
			.level_i(key_sync_q[k]),
			.press_cyc_i(press_cyc_i),
			.release_cyc_i(release_cyc_i),
			.press_o(press_evt[k]),
			.release_o(release_evt[k])
		);
	end

	// Removal wins over a host write in the same cycle
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			enable_q <= kef_pkg::KEY_DETECT_ENABLE_RST;
		end
		else if (removal_i)
		begin
			enable_q <= 1'b0;
		end
		else if (key_detect_enable_wr_i)
		begin
			enable_q <= key_detect_enable_wdata_i;
		end
	end

	always_comb
	begin
		flags_d = flags_q;
		if (read_done_i)
		begin
			flags_d = '0;
		end
		if (!enable_q)
		begin
			flags_d = '0;
		end
		else
		begin
			// Sets are applied last so an event in the read cycle is not lost
			if (press_evt[0])
			begin
				flags_d[kef_pkg::BIT_K1_PRESS] = 1'b1;
				flags_d[kef_pkg::BIT_K1_RELEASE] = 1'b0;
			end
			if (release_evt[0])
			begin
				flags_d[kef_pkg::BIT_K1_RELEASE] = 1'b1;
			end
			if (press_evt[1])
			begin
				flags_d[kef_pkg::BIT_K2_PRESS] = 1'b1;
				flags_d[kef_pkg::BIT_K2_RELEASE] = 1'b0;
			end
			if (release_evt[1])
			begin
				flags_d[kef_pkg::BIT_K2_RELEASE] = 1'b1;
			end
			// Key 3 release lives above this bank; its press is kept alone
			if (press_evt[2])
			begin
				flags_d[kef_pkg::BIT_K3_PRESS] = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flags_q <= kef_pkg::FLAGS_RST;
		end
		else
		begin
			flags_q <= flags_d;
		end
	end

	assign key_detect_enable_o = enable_q;
	assign rd_data_o = {{(kef_pkg::REG_W - kef_pkg::FLAG_W){1'b0}}, flags_q};

	sequence s_removal_taken;
		removal_i ##1 !enable_q;
	endsequence
	sequence s_flags_empty;
		flags_q == '0;
	endsequence
	// No strobe, detection enabled and no qualified event: nothing may move a flag
	sequence s_quiet;
		!read_done_i && enable_q && !(|press_evt) && !(|release_evt);
	endsequence

	// Every flag that rises must have a qualified event behind it
	AST_K1_PRESS_CAUSE: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n)
		$rose(flags_q[kef_pkg::BIT_K1_PRESS]) |-> $past(press_evt[0]))
		else $error("key 1 press flag set without a qualified press");
	AST_K2_PRESS_CAUSE: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n)
		$rose(flags_q[kef_pkg::BIT_K2_PRESS]) |-> $past(press_evt[1]))
		else $error("key 2 press flag set without a qualified press");
	AST_K3_PRESS_CAUSE: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n)
		$rose(flags_q[kef_pkg::BIT_K3_PRESS]) |-> $past(press_evt[2]) && $past(enable_q))
		else $error("key 3 press flag set without a qualified press");
	AST_K1_RELEASE_CAUSE: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n)
		$rose(flags_q[kef_pkg::BIT_K1_RELEASE]) |-> $past(release_evt[0]))
		else $error("key 1 release flag set without a qualified release");
	AST_K2_RELEASE_CAUSE: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n)
		$rose(flags_q[kef_pkg::BIT_K2_RELEASE]) |-> $past(release_evt[1]))
		else $error("key 2 release flag set without a qualified release");

	AST_READ_CLEARS: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n)
		read_done_i && !(|press_evt) && !(|release_evt) |=> s_flags_empty)
		else $error("flags not cleared by host read");
	AST_READ_SET_WINS: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n)
		read_done_i && enable_q && press_evt[1] |=> flags_q[kef_pkg::BIT_K2_PRESS])
		else $error("press event lost in the read cycle");

	AST_DISABLE_CLEARS: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n)
		key_detect_enable_wr_i && !key_detect_enable_wdata_i ##1 !enable_q
		|=> s_flags_empty [*2])
		else $error("flags not cleared while detection disabled");
	AST_DISABLED_EMPTY: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n)
		!enable_q && !$past(enable_q) |-> s_flags_empty)
		else $error("flag held while detection disabled");
	AST_WRITE_TAKEN: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n)
		key_detect_enable_wr_i && !removal_i
		|=> enable_q == $past(key_detect_enable_wdata_i))
		else $error("enable write not taken");

	AST_REMOVAL_CLEARS: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n)
		s_removal_taken |=> s_flags_empty)
		else $error("removal did not clear enable and flags");
	AST_REMOVAL_BEATS_WRITE: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n)
		removal_i |=> !enable_q)
		else $error("removal did not clear enable");

	AST_PRESS_KILLS_RELEASE: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n)
		enable_q && press_evt[0] |=> flags_q[kef_pkg::BIT_K1_PRESS]
		&& !flags_q[kef_pkg::BIT_K1_RELEASE])
		else $error("key 1 release flag survived a press");
	AST_K2_PRESS_KILLS_RELEASE: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n)
		enable_q && press_evt[1] |=> flags_q[kef_pkg::BIT_K2_PRESS]
		&& !flags_q[kef_pkg::BIT_K2_RELEASE])
		else $error("key 2 release flag survived a press");

	// A zero limit qualifies on the first differing cycle, so no history is owed then
	AST_K1_RAW_LEVEL: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n)
		press_evt[0] |-> key_sync_q[0]
		&& (press_cyc_i == '0 || $past(key_sync_q[0])))
		else $error("key 1 press not backed by the synchronised line");

	AST_FLAGS_HOLD: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n)
		s_quiet |=> $stable(flags_q))
		else $error("flags moved without a cause");
	AST_UPPER_ZERO: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n)
		rd_data_o[kef_pkg::REG_W-1:kef_pkg::FLAG_W] == '0)
		else $error("bits above the bank read non-zero");
endmodule : kef_flags

// [tb/kef_host_model.sv]
// Host model that turns bench requests into register read and write strobes
`timescale 1ns/1ps
module kef_host_model (
	input wire logic ref_clk_i,
	input wire logic rd_req_i,
	input wire logic wr_req_i,
	input wire logic wr_val_i,
	output logic read_done_o,
	output logic wr_o,
	output logic wdata_o
);
	// Strobes follow the requests one cycle later; idle write data toggles so a stale value never looks valid
	always_ff @(posedge ref_clk_i)
	begin
		read_done_o <= rd_req_i;
		wr_o <= wr_req_i;
		wdata_o <= wr_req_i ? wr_val_i : ~wdata_o;
	end
endmodule : kef_host_model

// [tb/kef_flags_tb.sv]
// Self-checking bench for the key event flag bank
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin n_errors++; \
	$display("Error %s expected %h seen %h", nm, ex, gt); end end
module kef_flags_tb;
	logic ref_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [kef_pkg::NUM_KEYS-1:0] key_q = '0;
	logic [kef_pkg::CNT_W-1:0] pc = 24'h00_0002;
	logic [kef_pkg::CNT_W-1:0] rc = 24'h00_0002;
	logic rd_req = 1'b0;
	logic wr_req = 1'b0;
	logic wr_val = 1'b0;
	logic removal = 1'b0;
	logic read_done, wr, wdata, en;
	logic [kef_pkg::REG_W-1:0] rd_data;
	logic [7:0] exp = 8'h00;
	int checks = 0;
	int n_errors = 0;
	int k;

	kef_host_model u_kef_host_model (.ref_clk_i(ref_clk_i), .rd_req_i(rd_req), .wr_req_i(wr_req),
		.wr_val_i(wr_val), .read_done_o(read_done), .wr_o(wr), .wdata_o(wdata));
	kef_flags u_kef_flags (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .key_pressed_i(key_q),
		.press_cyc_i(pc), .release_cyc_i(rc), .key_detect_enable_wr_i(wr),
		.key_detect_enable_wdata_i(wdata), .removal_i(removal), .read_done_i(read_done),
		.key_detect_enable_o(en), .rd_data_o(rd_data));

	initial
	begin
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end

	function automatic logic [7:0] next_flags(logic [7:0] f, int key, logic p);
		logic [7:0] r;
		r = f;
		if (p)
		begin
			r[2*key] = 1'b1;
			if (key < 2) r[2*key+1] = 1'b0;
		end
		else if (key < 2) r[2*key+1] = 1'b1;
		return r;
	endfunction : next_flags

	task automatic tally_and_finish();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	// Flag must still be old one edge before the qualified event lands
	task automatic key_evt(input int key, input logic p);
		int lim;
		lim = p ? int'(pc) : int'(rc);
		@(posedge ref_clk_i) key_q[key] <= p;
		repeat (lim + 2) @(posedge ref_clk_i);
		#1 `CHK("flags early", exp, rd_data)
		@(posedge ref_clk_i);
		#1 exp = next_flags(exp, key, p);
		`CHK("flags", exp, rd_data)
	endtask : key_evt

	task automatic host_op(input logic rd, input logic v);
		@(posedge ref_clk_i);
		rd_req <= rd;
		wr_req <= ~rd;
		wr_val <= v;
		@(posedge ref_clk_i);
		rd_req <= 1'b0;
		wr_req <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		#1;
	endtask : host_op

	initial
	begin
		#(5ns * 6000);
		n_errors++;
		tally_and_finish();
	end

	initial
	begin
		void'($urandom(86));
		pc = 24'($urandom_range(5, 2));
		rc = 24'($urandom_range(5, 2));
		repeat (12) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		#1 `CHK("reset flags", 8'h00, rd_data)
		`CHK("reset enable", 1'b1, en)
		for (int i = 0; i < 8; i++) key_evt(i / 3, ~key_q[i / 3]);
		repeat (10)
		begin
			k = $urandom_range(2, 0);
			key_evt(k, ~key_q[k]);
		end
		host_op(1'b1, 1'b0);
		exp = 8'h00;
		`CHK("read clear", exp, rd_data)
		key_evt(0, ~key_q[0]);
		host_op(1'b0, 1'b0);
		`CHK("disable en", 1'b0, en)
		`CHK("disable clear", 8'h00, rd_data)
		@(posedge ref_clk_i) key_q <= 3'h7;
		repeat (12) @(posedge ref_clk_i);
		#1 `CHK("disabled events", 8'h00, rd_data)
		@(posedge ref_clk_i) key_q <= 3'h0;
		repeat (12) @(posedge ref_clk_i);
		host_op(1'b0, 1'b1);
		exp = 8'h00;
		key_evt(1, 1'b1);
		key_evt(1, 1'b0);
		// Read strobe lands in the cycle the key 2 press qualifies; the set must survive
		@(posedge ref_clk_i) key_q[1] <= 1'b1;
		repeat (int'(pc) + 1) @(posedge ref_clk_i);
		rd_req <= 1'b1;
		@(posedge ref_clk_i) rd_req <= 1'b0;
		@(posedge ref_clk_i);
		#1 exp = 8'h04;
		`CHK("read with press", exp, rd_data)
		@(posedge ref_clk_i) removal <= 1'b1;
		@(posedge ref_clk_i) removal <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		#1 `CHK("removal en", 1'b0, en)
		`CHK("removal clear", 8'h00, rd_data)
		// Write of one and removal reach the design in the same cycle
		@(posedge ref_clk_i) wr_req <= 1'b1;
		wr_val <= 1'b1;
		@(posedge ref_clk_i) wr_req <= 1'b0;
		removal <= 1'b1;
		@(posedge ref_clk_i) removal <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		#1 `CHK("removal beats write", 1'b0, en)
		tally_and_finish();
	end
endmodule : kef_flags_tb
